// file: rtl/mitc_top.sv
// maskable interrupt controller with trap and exception entry for the cpu core
// assumes core presents at most one instruction event per cycle and
// obeys the redirect in the following cycle
`timescale 1ns/100ps
module mitc_top
  import mitc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [NUM_SRC-1:0] src_req_i,
  input wire logic [PINS_PER_GRP-1:0] ext_irq_group0_pins_i,
  input wire logic [PINS_PER_GRP-1:0] ext_irq_group1_pins_i,
  input wire mitc_per_access_type per_bus_i,
  output logic [7:0] per_rdata_o,
  input wire mitc_cpu_event_type cpu_evt_i,
  input wire logic [4:0] sreg_rd_id_i,
  output logic [31:0] sreg_rdata_o,
  output mitc_redirect_type redirect_o,
  output logic [31:0] program_status_word_o,
  output logic [NUM_LVL-1:0] in_service_levels_o
);
  ////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic [SRC_W:0] src_hit(input logic [31:0] a);
    logic [31:0] off;
    off = a - ADDR_IC_BASE;
    if (off < 32'(NUM_SRC))
      return {1'b1, off[SRC_W-1:0]};
    return '0;
  endfunction

  // lowest set index is the level in service; msb flags empty
  function automatic logic [LVL_W:0] in_service_levels_top(input logic [NUM_LVL-1:0] v);
    logic [LVL_W:0] r;
    r = {1'b1, {LVL_W{1'b0}}};
    for (int k = NUM_LVL - 1; k >= 0; k--)
      if (v[k])
        r = {1'b0, LVL_W'(k)};
    return r;
  endfunction

  function automatic logic bad_opcode(input logic [31:0] w);
    return (w[ILG_SUB_MSB:ILG_SUB_LSB] == ILG_SUB_VAL) &&
      (w[ILG_OP_MSB:ILG_OP_LSB] >= ILG_OP_MIN);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] ic_reg [NUM_SRC];
  logic [7:0] ic_next [NUM_SRC];
  logic [7:0] edge_g0_reg, edge_g0_next;
  logic [7:0] edge_g1_reg, edge_g1_next;
  logic [7:0] per_rdata_reg, per_rdata_next;
  logic [31:0] psw_reg, psw_next;
  logic [31:0] saved_int_pc_reg, saved_int_pc_next;
  logic [31:0] saved_int_status_word_reg, saved_int_status_word_next;
  logic [31:0] ecr_reg, ecr_next;
  logic [NUM_LVL-1:0] in_service_levels_reg, in_service_levels_next;
  logic [31:0] sreg_rdata_reg, sreg_rdata_next;
  mitc_redirect_type redirect_reg, redirect_next;

  logic [EXT_PINS-1:0] pin_pulse;
  logic [NUM_SRC-1:0] src_evt;
  logic best_found;
  logic [LVL_W-1:0] best_lvl;
  logic [SRC_W-1:0] best_idx;
  logic [LVL_W:0] top_lvl;
  logic int_ok;
  logic accept_int;
  logic evt_ilg;
  logic evt_trap;
  logic core_busy;
  logic [15:0] int_code;
  logic [SRC_W:0] wr_hit;
  logic [SRC_W:0] rd_hit;

  ////////////////////////////////////////////////////////////////////////
  // request sources
  mitc_edge_detect #(.PINS(EXT_PINS)) u_edge (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .pins_i({ext_irq_group1_pins_i, ext_irq_group0_pins_i}),
    .codes_i({edge_g1_reg, edge_g0_reg}),
    .pulse_o(pin_pulse)
  );

  always_comb
  begin
    src_evt = src_req_i;
    src_evt[GRP0_FIRST_SRC +: PINS_PER_GRP] =
      src_req_i[GRP0_FIRST_SRC +: PINS_PER_GRP] | pin_pulse[PINS_PER_GRP-1:0];
    src_evt[GRP1_FIRST_SRC +: PINS_PER_GRP] =
      src_req_i[GRP1_FIRST_SRC +: PINS_PER_GRP] | pin_pulse[EXT_PINS-1:PINS_PER_GRP];
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration
  always_comb
  begin
    best_found = 1'b0;
    best_lvl = {LVL_W{1'b1}};
    best_idx = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      // strict compare keeps the lower source number on a tie
      if (ic_reg[i][IC_PEND_BIT] && !ic_reg[i][IC_MASK_BIT] &&
          (!best_found || ic_reg[i][IC_PRIO_LSB +: LVL_W] < best_lvl))
      begin
        best_found = 1'b1;
        best_lvl = ic_reg[i][IC_PRIO_LSB +: LVL_W];
        best_idx = SRC_W'(i);
      end
    end
  end

  assign top_lvl = in_service_levels_top(in_service_levels_reg);
  assign int_ok = best_found && !psw_reg[PSW_ID_BIT] && !psw_reg[PSW_NP_BIT] &&
    (top_lvl[LVL_W] || best_lvl < top_lvl[LVL_W-1:0]);
  assign evt_ilg = cpu_evt_i.instr_valid && bad_opcode(cpu_evt_i.instr);
  assign evt_trap = cpu_evt_i.trap && !evt_ilg;
  assign core_busy = evt_ilg || cpu_evt_i.trap || cpu_evt_i.return_from_handler_instr || cpu_evt_i.ei ||
    cpu_evt_i.di || cpu_evt_i.load_system_reg_instr;
  assign accept_int = int_ok && !core_busy;
  assign int_code = CODE_INT_BASE + (16'(best_idx) << CODE_INT_SHIFT);
  assign wr_hit = src_hit(per_bus_i.addr);
  assign rd_hit = src_hit(per_bus_i.addr);

  ////////////////////////////////////////////////////////////////////////
  // peripheral registers
  always_comb
  begin
    edge_g0_next = edge_g0_reg;
    edge_g1_next = edge_g1_reg;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      ic_next[i] = ic_reg[i];
      if (per_bus_i.wr && wr_hit[SRC_W] && wr_hit[SRC_W-1:0] == SRC_W'(i))
        ic_next[i] = per_bus_i.wdata & IC_USED_MASK;
      if (accept_int && best_idx == SRC_W'(i))
        ic_next[i][IC_PEND_BIT] = 1'b0;
      if (src_evt[i])
        ic_next[i][IC_PEND_BIT] = 1'b1;
    end
    if (per_bus_i.wr && per_bus_i.addr == ADDR_EDGE_G0)
      edge_g0_next = per_bus_i.wdata;
    if (per_bus_i.wr && per_bus_i.addr == ADDR_EDGE_G1)
      edge_g1_next = per_bus_i.wdata;
    per_rdata_next = per_rdata_reg;
    if (per_bus_i.rd)
    begin
      if (rd_hit[SRC_W])
        per_rdata_next = ic_reg[rd_hit[SRC_W-1:0]];
      else if (per_bus_i.addr == ADDR_EDGE_G0)
        per_rdata_next = edge_g0_reg;
      else if (per_bus_i.addr == ADDR_EDGE_G1)
        per_rdata_next = edge_g1_reg;
      else if (per_bus_i.addr == ADDR_IN_SERVICE_LEVELS)
        per_rdata_next = in_service_levels_reg;
      else
        per_rdata_next = 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NUM_SRC; i++)
        ic_reg[i] <= IC_RESET;
      edge_g0_reg <= EDGE_RESET;
      edge_g1_reg <= EDGE_RESET;
      per_rdata_reg <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < NUM_SRC; i++)
        ic_reg[i] <= ic_next[i];
      edge_g0_reg <= edge_g0_next;
      edge_g1_reg <= edge_g1_next;
      per_rdata_reg <= per_rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core state: status word, saved registers, in-service levels
  always_comb
  begin
    psw_next = psw_reg;
    saved_int_pc_next = saved_int_pc_reg;
    saved_int_status_word_next = saved_int_status_word_reg;
    ecr_next = ecr_reg;
    in_service_levels_next = in_service_levels_reg;
    redirect_next = '0;
    if (evt_ilg || evt_trap)
    begin
      // taken regardless of the block flag
      saved_int_pc_next = cpu_evt_i.next_pc;
      saved_int_status_word_next = psw_reg;
      ecr_next[15:0] = evt_ilg ? CODE_BAD_OPCODE_EXCEPTION : CODE_TRAP_BASE + 16'(cpu_evt_i.trap_op);
      psw_next[PSW_EP_BIT] = 1'b1;
      psw_next[PSW_ID_BIT] = 1'b1;
      redirect_next.valid = 1'b1;
      redirect_next.code = ecr_next[15:0];
      if (evt_ilg)
        redirect_next.pc = 32'(CODE_BAD_OPCODE_EXCEPTION);
      else
        redirect_next.pc = cpu_evt_i.trap_op[TRAP_HI_BIT] ? VEC_TRAP_HI : VEC_TRAP_LO;
    end
    else if (cpu_evt_i.return_from_handler_instr)
    begin
      if (psw_reg[PSW_EP_BIT] || !psw_reg[PSW_NP_BIT])
      begin
        psw_next = saved_int_status_word_reg & PSW_WR_MASK;
        redirect_next.valid = 1'b1;
        redirect_next.pc = saved_int_pc_reg;
      end
      if (!psw_reg[PSW_EP_BIT] && !psw_reg[PSW_NP_BIT] && !top_lvl[LVL_W])
        in_service_levels_next[top_lvl[LVL_W-1:0]] = 1'b0;
    end
    else if (cpu_evt_i.ei)
      psw_next[PSW_ID_BIT] = 1'b0;
    else if (cpu_evt_i.di)
      psw_next[PSW_ID_BIT] = 1'b1;
    else if (cpu_evt_i.load_system_reg_instr)
    begin
      unique case (cpu_evt_i.sreg_id)
        SREG_SAVED_INT_PC: saved_int_pc_next = cpu_evt_i.sreg_wdata;
        SREG_SAVED_INT_STATUS_WORD: saved_int_status_word_next = cpu_evt_i.sreg_wdata & PSW_WR_MASK;
        SREG_ECR: ecr_next = ecr_reg;
        SREG_PSW: psw_next = cpu_evt_i.sreg_wdata & PSW_WR_MASK;
        default: psw_next = psw_reg;
      endcase
    end
    else if (accept_int)
    begin
      saved_int_pc_next = cpu_evt_i.next_pc;
      saved_int_status_word_next = psw_reg;
      ecr_next[15:0] = int_code;
      psw_next[PSW_ID_BIT] = 1'b1;
      psw_next[PSW_EP_BIT] = 1'b0;
      in_service_levels_next[best_lvl] = 1'b1;
      redirect_next.valid = 1'b1;
      redirect_next.code = int_code;
      redirect_next.pc = 32'(int_code);
    end
    unique case (sreg_rd_id_i)
      SREG_SAVED_INT_PC: sreg_rdata_next = saved_int_pc_reg;
      SREG_SAVED_INT_STATUS_WORD: sreg_rdata_next = saved_int_status_word_reg;
      SREG_ECR: sreg_rdata_next = ecr_reg;
      SREG_PSW: sreg_rdata_next = psw_reg;
      default: sreg_rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      psw_reg <= PSW_RESET;
      saved_int_pc_reg <= 32'h00000000;
      saved_int_status_word_reg <= 32'h00000000;
      ecr_reg <= 32'h00000000;
      in_service_levels_reg <= '0;
      redirect_reg <= '0;
      sreg_rdata_reg <= 32'h00000000;
    end
    else
    begin
      psw_reg <= psw_next;
      saved_int_pc_reg <= saved_int_pc_next;
      saved_int_status_word_reg <= saved_int_status_word_next;
      ecr_reg <= ecr_next;
      in_service_levels_reg <= in_service_levels_next;
      redirect_reg <= redirect_next;
      sreg_rdata_reg <= sreg_rdata_next;
    end
  end

  assign per_rdata_o = per_rdata_reg;
  assign sreg_rdata_o = sreg_rdata_reg;
  assign redirect_o = redirect_reg;
  assign program_status_word_o = psw_reg;
  assign in_service_levels_o = in_service_levels_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  int_entry_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    accept_int |=> redirect_reg.valid && redirect_reg.pc == 32'($past(int_code)) &&
      psw_reg[PSW_ID_BIT] && !psw_reg[PSW_EP_BIT] && saved_int_pc_reg == $past(cpu_evt_i.next_pc) &&
      saved_int_status_word_reg == $past(psw_reg) && ecr_reg[15:0] == $past(int_code))
    else $error("maskable entry state wrong");

  mask_holds_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    accept_int |-> !ic_reg[best_idx][IC_MASK_BIT] && ic_reg[best_idx][IC_PEND_BIT])
    else $error("masked or idle source accepted");

  block_holds_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (psw_reg[PSW_ID_BIT] || psw_reg[PSW_NP_BIT]) |-> !accept_int)
    else $error("request accepted while blocked");

  preempt_level_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (accept_int && in_service_levels_reg != '0) |-> best_lvl < top_lvl[LVL_W-1:0])
    else $error("nesting at equal or lower level");

  in_service_levels_set_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    accept_int |=> in_service_levels_reg[$past(best_lvl)] && !ic_reg[$past(best_idx)][IC_MASK_BIT])
    else $error("in-service bit not set on accept");

  trap_vec_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    evt_trap |=> redirect_reg.valid &&
      redirect_reg.pc == ($past(cpu_evt_i.trap_op[TRAP_HI_BIT]) ? VEC_TRAP_HI : VEC_TRAP_LO))
    else $error("trap vector wrong");

  trap_flags_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (evt_trap || evt_ilg) |=> psw_reg[PSW_EP_BIT] && psw_reg[PSW_ID_BIT] &&
      saved_int_status_word_reg == $past(psw_reg) && saved_int_pc_reg == $past(cpu_evt_i.next_pc))
    else $error("trap entry flags or saves wrong");

  bad_opcode_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (cpu_evt_i.instr_valid && cpu_evt_i.instr[ILG_SUB_MSB:ILG_SUB_LSB] == ILG_SUB_VAL &&
      cpu_evt_i.instr[ILG_OP_MSB:ILG_OP_LSB] >= ILG_OP_MIN) |=> ecr_reg[15:0] == CODE_BAD_OPCODE_EXCEPTION)
    else $error("bad opcode not raised");

  return_from_handler_instr_in_service_levels_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (cpu_evt_i.return_from_handler_instr && !cpu_evt_i.trap && !evt_ilg && in_service_levels_reg != '0) |=>
      $countones(in_service_levels_reg) == $countones($past(in_service_levels_reg)) -
        (($past(psw_reg[PSW_EP_BIT]) || $past(psw_reg[PSW_NP_BIT])) ? 0 : 1))
    else $error("in-service clear on return wrong");

  return_from_handler_instr_restore_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (cpu_evt_i.return_from_handler_instr && !cpu_evt_i.trap && !evt_ilg &&
      (psw_reg[PSW_EP_BIT] || !psw_reg[PSW_NP_BIT])) |=>
      redirect_reg.pc == $past(saved_int_pc_reg) && psw_reg == ($past(saved_int_status_word_reg) & PSW_WR_MASK))
    else $error("return did not restore");

  return_from_handler_instr_refused_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (cpu_evt_i.return_from_handler_instr && !cpu_evt_i.trap && !evt_ilg && !psw_reg[PSW_EP_BIT] &&
      psw_reg[PSW_NP_BIT]) |=> !redirect_reg.valid && psw_reg == $past(psw_reg))
    else $error("nonmaskable return not left alone");

  unblock_instr_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (cpu_evt_i.ei && !cpu_evt_i.trap && !cpu_evt_i.return_from_handler_instr && !evt_ilg) |=>
      !psw_reg[PSW_ID_BIT] && !redirect_reg.valid)
    else $error("unblock did not clear block flag");
endmodule

// file: rtl/mitc_pkg.sv
// constants, types and field layouts of the maskable interrupt and trap control block
// assumes a single system clock and one cpu event per cycle from the core
// Operation
// - fourteen maskable sources, each with own mask
// - best programmed level wins, default order breaks ties
// - with block clear, only strictly higher level preempts
// - interrupt entry saves pc, status, cause; jumps
// - masked or blocked requests stay pending until allowed
// - return restores pc, status when trap, nmi clear
// - pending bit 7 set by request, cleared on accept
// - mask bit 6 holds request pending when set
// - bits 2-0 give level, 0 highest, 7 lowest
// - two-bit edge code per external pin
// - group-0 and group-1 edge registers, group-1 reset zero
// - in-service bit of accepted level set, read-only
// - return clears highest in-service bit, not from traps
// - status bit 5 blocks maskable; set, clear, rewrite
// - traps and exceptions ignore the block flag
// - trap always taken; vector by operand half
// - trap entry saves state, sets trap and block
// - return with trap flag restores saved pc, status
// - status bit 6 marks trap in progress
// - status bit 7 marks nonmaskable handling active
// - bad opcode decoded from bits 5-10 and 23-26
// - default priority: lower source number wins
// - source control resets masked at level 7
package mitc_pkg;
  localparam int NUM_SRC = 14;
  localparam int NUM_LVL = 8;
  localparam int LVL_W = 3;
  localparam int SRC_W = 4;
  localparam int PINS_PER_GRP = 4;
  localparam int EXT_PINS = 8;
  localparam int GRP0_FIRST_SRC = 10;
  localparam int GRP1_FIRST_SRC = 1;

  // source control layout
  localparam int IC_PEND_BIT = 7;
  localparam int IC_MASK_BIT = 6;
  localparam int IC_PRIO_LSB = 0;
  localparam logic [7:0] IC_RESET = 8'h47;
  localparam logic [7:0] IC_USED_MASK = 8'hc7;

  // edge codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_RSVD = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [7:0] EDGE_RESET = 8'h00;

  // peripheral addresses
  localparam logic [31:0] ADDR_IC_BASE = 32'hfffff110;
  localparam logic [31:0] ADDR_EDGE_G0 = 32'hfffff180;
  localparam logic [31:0] ADDR_EDGE_G1 = 32'hfffff184;
  localparam logic [31:0] ADDR_IN_SERVICE_LEVELS = 32'hfffff188;

  // status word
  localparam int PSW_NP_BIT = 7;
  localparam int PSW_EP_BIT = 6;
  localparam int PSW_ID_BIT = 5;
  localparam logic [31:0] PSW_RESET = 32'h00000020;
  localparam logic [31:0] PSW_WR_MASK = 32'h000000ff;

  // system register numbers
  localparam logic [4:0] SREG_SAVED_INT_PC = 5'h00;
  localparam logic [4:0] SREG_SAVED_INT_STATUS_WORD = 5'h01;
  localparam logic [4:0] SREG_ECR = 5'h04;
  localparam logic [4:0] SREG_PSW = 5'h05;

  // cause codes and vectors
  localparam logic [15:0] CODE_TRAP_BASE = 16'h0040;
  localparam logic [15:0] CODE_BAD_OPCODE_EXCEPTION = 16'h0060;
  localparam logic [15:0] CODE_INT_BASE = 16'h0080;
  localparam int CODE_INT_SHIFT = 4;
  localparam logic [31:0] VEC_TRAP_LO = 32'h00000040;
  localparam logic [31:0] VEC_TRAP_HI = 32'h00000050;
  localparam int TRAP_HI_BIT = 4;

  // bad opcode fields
  localparam int ILG_SUB_LSB = 5;
  localparam int ILG_SUB_MSB = 10;
  localparam logic [5:0] ILG_SUB_VAL = 6'h3f;
  localparam int ILG_OP_LSB = 23;
  localparam int ILG_OP_MSB = 26;
  localparam logic [3:0] ILG_OP_MIN = 4'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [7:0] wdata;
  } mitc_per_access_type;

  typedef struct packed {
    logic instr_valid;
    logic [31:0] instr;
    logic [31:0] next_pc;
    logic trap;
    logic [4:0] trap_op;
    logic return_from_handler_instr;
    logic ei;
    logic di;
    logic load_system_reg_instr;
    logic [4:0] sreg_id;
    logic [31:0] sreg_wdata;
  } mitc_cpu_event_type;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
    logic [31:0] pc;
  } mitc_redirect_type;
endpackage

// file: rtl/mitc_edge_detect.sv
// valid edge detection for the external request pins
// assumes pins already synchronous to sys_clk_i
`timescale 1ns/100ps
module mitc_edge_detect
  import mitc_pkg::*;
#(
  parameter int PINS = EXT_PINS
)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [PINS-1:0] pins_i,
  input wire logic [2*PINS-1:0] codes_i,
  output logic [PINS-1:0] pulse_o
);
  logic [PINS-1:0] prev_reg;
  logic [PINS-1:0] prev_next;

  always_comb
  begin
    prev_next = pins_i;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prev_reg <= '0;
    else
      prev_reg <= prev_next;
  end

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : gen_pin
      logic rise;
      logic fall;
      assign rise = pins_i[g] & ~prev_reg[g];
      assign fall = ~pins_i[g] & prev_reg[g];
      always_comb
      begin
        unique case (codes_i[2*g +: 2])
          EDGE_FALL: pulse_o[g] = fall;
          EDGE_RISE: pulse_o[g] = rise;
          EDGE_BOTH: pulse_o[g] = rise | fall;
          EDGE_RSVD: pulse_o[g] = 1'b0;
        endcase
      end
      rsvd_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (codes_i[2*g +: 2] == EDGE_RSVD) |-> !pulse_o[g])
        else $error("reserved edge code produced a request");
    end
  endgenerate
endmodule

// file: verif/mitc_core_model.sv
// partner model of the cpu core: follows every redirect and logs code and target
// assumes redirect_i is a one-cycle registered pulse from mitc_top
`timescale 1ns/100ps
module mitc_core_model
  import mitc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire mitc_redirect_type redirect_i,
  output logic [31:0] fetch_pc_o,
  output int taken_o
);
  logic [15:0] code_log [0:63];
  logic [31:0] pc_log [0:63];

  ////////////////////////////////////////////////////////////////
  // jump in the cycle after the pulse, one log entry per pulse
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fetch_pc_o <= 32'h00000000;
      taken_o <= 0;
    end
    else if (redirect_i.valid)
    begin
      fetch_pc_o <= redirect_i.pc;
      code_log[taken_o[5:0]] <= redirect_i.code;
      pc_log[taken_o[5:0]] <= redirect_i.pc;
      taken_o <= taken_o + 1;
    end
  end
endmodule

// file: verif/test_maskable_irq_and_trap_control.sv
// self-checking bench: registers, acceptance, nesting, traps, returns
// assumes mitc_core_model logs every redirect pulse of the block
`timescale 1ns/100ps
module test_maskable_irq_and_trap_control
  import mitc_pkg::*;
;
  localparam int K_TRAP = 0;
  localparam int K_RETURN_FROM_HANDLER_INSTR = 1;
  localparam int K_EI = 2;
  localparam int K_DI = 3;
  localparam int K_LOAD_SYSTEM_REG_INSTR = 4;
  localparam int K_INSTR = 5;
  logic sys_clk_i;
  logic reset_n_i;
  logic [NUM_SRC-1:0] src_req;
  logic [3:0] g0_pins;
  logic [3:0] g1_pins;
  mitc_per_access_type per_bus;
  logic [7:0] per_rdata;
  mitc_cpu_event_type evt;
  logic [4:0] sreg_id;
  logic [4:0] load_system_reg_instr_id;
  logic [31:0] sreg_rdata;
  mitc_redirect_type redirect;
  logic [31:0] program_status_word;
  logic [7:0] isl;
  int taken;
  int mismatches;
  int num_checks;
  int exp_cnt;
  logic [15:0] order [3] = '{16'h0110, 16'h00e0, 16'h00f0};

  mitc_top u_mitc_top (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .src_req_i(src_req),
    .ext_irq_group0_pins_i(g0_pins), .ext_irq_group1_pins_i(g1_pins), .per_bus_i(per_bus),
    .per_rdata_o(per_rdata), .cpu_evt_i(evt), .sreg_rd_id_i(sreg_id),
    .sreg_rdata_o(sreg_rdata), .redirect_o(redirect), .program_status_word_o(program_status_word),
    .in_service_levels_o(isl));
  mitc_core_model u_mitc_core_model (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .redirect_i(redirect), .fetch_pc_o(), .taken_o(taken));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic per_wr(input logic [31:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    per_bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk_i);
    per_bus.wr = 1'b0;
  endtask
  task automatic per_rd(input logic [31:0] a, input logic [7:0] e);
    @(negedge sys_clk_i);
    per_bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk_i);
    per_bus.rd = 1'b0;
    @(negedge sys_clk_i);
    chk({24'h0, per_rdata}, {24'h0, e});
  endtask
  task automatic sreg_chk(input logic [4:0] id, input logic [31:0] e);
    @(negedge sys_clk_i);
    sreg_id = id;
    tick(2);
    chk(sreg_rdata, e);
  endtask
  task automatic ev(input int k, input logic [31:0] x);
    @(negedge sys_clk_i);
    {evt.trap, evt.return_from_handler_instr, evt.ei, evt.di, evt.load_system_reg_instr, evt.instr_valid} = 6'h20 >> k;
    evt.trap_op = x[4:0];
    evt.sreg_id = load_system_reg_instr_id;
    evt.sreg_wdata = x;
    evt.instr = x;
    @(negedge sys_clk_i);
    {evt.trap, evt.return_from_handler_instr, evt.ei, evt.di, evt.load_system_reg_instr, evt.instr_valid} = 6'h00;
  endtask
  task automatic pulse(input logic [NUM_SRC-1:0] m);
    @(negedge sys_clk_i);
    src_req = m;
    @(negedge sys_clk_i);
    src_req = '0;
  endtask
  task automatic redir(input logic [15:0] c, input logic [31:0] p);
    exp_cnt++;
    for (int k = 0; k < 40 && taken < exp_cnt; k++) @(negedge sys_clk_i);
    chk(32'(taken), 32'(exp_cnt));
    chk({16'h0, u_mitc_core_model.code_log[exp_cnt-1]}, {16'h0, c});
    chk(u_mitc_core_model.pc_log[exp_cnt-1], p);
  endtask
  task automatic quiet();
    tick(6);
    chk(32'(taken), 32'(exp_cnt));
  endtask
  task automatic serve(input logic [15:0] c);
    redir(c, {16'h0, c});
    ev(K_RETURN_FROM_HANDLER_INSTR, 0);
    redir(16'h0, 32'h1000);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    repeat (6000) @(posedge sys_clk_i);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    reset_n_i = 1'b0;
    src_req = '0;
    g0_pins = 4'h0;
    g1_pins = 4'h0;
    per_bus = '0;
    evt = '0;
    evt.next_pc = 32'h1000;
    sreg_id = SREG_SAVED_INT_PC;
    load_system_reg_instr_id = SREG_PSW;
    mismatches = 0;
    num_checks = 0;
    exp_cnt = 0;
    tick(16);
    reset_n_i = 1'b1;
    per_rd(ADDR_IC_BASE, 8'h47);
    per_rd(ADDR_IC_BASE + 13, 8'h47);
    per_rd(ADDR_EDGE_G1, 8'h00);
    chk(program_status_word, 32'h20);
    chk({24'h0, isl}, 32'h0);
    per_wr(ADDR_IN_SERVICE_LEVELS, 8'hff);
    per_rd(ADDR_IN_SERVICE_LEVELS, 8'h00);
    per_rd(32'hfffff1f0, 8'h00);
    per_wr(ADDR_IC_BASE, 8'h7f);
    per_rd(ADDR_IC_BASE, 8'h47);
    $display("test registers done");
    per_wr(ADDR_EDGE_G1, 8'h09);
    per_rd(ADDR_EDGE_G1, 8'h09);
    per_wr(ADDR_EDGE_G0, 8'h03);
    g1_pins = 4'h3;
    g0_pins = 4'h3;
    tick(2);
    per_wr(ADDR_IC_BASE + 10, 8'h47);
    per_rd(ADDR_IC_BASE + 11, 8'h47);
    g0_pins = 4'h0;
    g1_pins = 4'h0;
    tick(2);
    per_rd(ADDR_IC_BASE + 1, 8'hc7);
    per_rd(ADDR_IC_BASE + 2, 8'h47);
    per_rd(ADDR_IC_BASE + 10, 8'hc7);
    per_rd(ADDR_IC_BASE + 11, 8'hc7);
    per_wr(ADDR_IC_BASE + 1, 8'h47);
    per_wr(ADDR_IC_BASE + 10, 8'h47);
    $display("test edges done");
    ev(K_EI, 0);
    chk(program_status_word, 32'h0);
    pulse(14'h0008);
    quiet();
    per_rd(ADDR_IC_BASE + 3, 8'hc7);
    per_wr(ADDR_IC_BASE + 3, 8'h82);
    redir(16'h00b0, 32'hb0);
    chk(program_status_word, 32'h20);
    chk({24'h0, isl}, 32'h04);
    per_rd(ADDR_IC_BASE + 3, 8'h02);
    sreg_chk(SREG_SAVED_INT_PC, 32'h1000);
    sreg_chk(SREG_SAVED_INT_STATUS_WORD, 32'h0);
    sreg_chk(SREG_ECR, 32'hb0);
    $display("test accept done");
    per_wr(ADDR_IC_BASE, 8'h02);
    per_wr(ADDR_IC_BASE + 5, 8'h01);
    ev(K_EI, 0);
    pulse(14'h0001);
    quiet();
    pulse(14'h0020);
    redir(16'h00d0, 32'hd0);
    chk({24'h0, isl}, 32'h06);
    ev(K_RETURN_FROM_HANDLER_INSTR, 0);
    redir(16'h0, 32'h1000);
    chk({24'h0, isl}, 32'h04);
    quiet();
    ev(K_RETURN_FROM_HANDLER_INSTR, 0);
    redir(16'h0, 32'h1000);
    serve(16'h0080);
    chk({24'h0, isl}, 32'h0);
    $display("test nesting done");
    ev(K_DI, 0);
    chk(program_status_word, 32'h20);
    per_wr(ADDR_IC_BASE + 6, 8'h03);
    per_wr(ADDR_IC_BASE + 7, 8'h03);
    per_wr(ADDR_IC_BASE + 9, 8'h01);
    pulse(14'h02c0);
    quiet();
    ev(K_EI, 0);
    foreach (order[i]) serve(order[i]);
    $display("test arbitration done");
    evt.next_pc = 32'h2000;
    pulse(14'h0008);
    redir(16'h00b0, 32'hb0);
    ev(K_TRAP, 32'h05);
    redir(16'h0045, 32'h40);
    chk(program_status_word, 32'h60);
    sreg_chk(SREG_ECR, 32'h45);
    sreg_chk(SREG_SAVED_INT_STATUS_WORD, 32'h20);
    ev(K_TRAP, 32'h15);
    redir(16'h0055, 32'h50);
    ev(K_RETURN_FROM_HANDLER_INSTR, 0);
    redir(16'h0, 32'h2000);
    chk({24'h0, isl}, 32'h04);
    ev(K_LOAD_SYSTEM_REG_INSTR, 32'h20);
    chk(program_status_word, 32'h20);
    ev(K_RETURN_FROM_HANDLER_INSTR, 0);
    redir(16'h0, 32'h2000);
    chk({24'h0, isl}, 32'h0);
    ev(K_LOAD_SYSTEM_REG_INSTR, 32'h0);
    $display("test traps done");
    ev(K_INSTR, 32'h010007e0);
    quiet();
    ev(K_INSTR, 32'h018007e0);
    redir(CODE_BAD_OPCODE_EXCEPTION, 32'h60);
    chk(program_status_word, 32'h60);
    $display("test opcode done");
    load_system_reg_instr_id = SREG_SAVED_INT_PC;
    ev(K_LOAD_SYSTEM_REG_INSTR, 32'h3000);
    sreg_chk(SREG_SAVED_INT_PC, 32'h3000);
    load_system_reg_instr_id = SREG_SAVED_INT_STATUS_WORD;
    ev(K_LOAD_SYSTEM_REG_INSTR, 32'h1ff);
    sreg_chk(SREG_SAVED_INT_STATUS_WORD, 32'hff);
    load_system_reg_instr_id = SREG_ECR;
    ev(K_LOAD_SYSTEM_REG_INSTR, 32'h1234);
    sreg_chk(SREG_ECR, 32'h60);
    load_system_reg_instr_id = SREG_PSW;
    ev(K_LOAD_SYSTEM_REG_INSTR, 32'h80);
    chk(program_status_word, 32'h80);
    pulse(14'h0008);
    quiet();
    ev(K_RETURN_FROM_HANDLER_INSTR, 0);
    quiet();
    ev(K_LOAD_SYSTEM_REG_INSTR, 32'h0);
    redir(16'h00b0, 32'hb0);
    $display("test nonmask flag done");
    print_verdict();
  end
endmodule
